// ===== rtl/bcd_opcode_table.sv
/*
  Combinational opcode table: class, operands, length and machine
  cycles for one opcode byte. Assumes the caller registers its outputs.
*/
`timescale 1ns/100ps
module bcd_opcode_table
  import bcd_pkg::*;
(
  input wire logic [7:0] opcode,
  output bcd_op_t op,
  output bcd_src_t src,
  output bcd_dst_t dst,
  output logic [1:0] len,
  output logic [2:0] mcycles,
  output logic known
);
  function automatic bcd_op_t fam_op(input logic [3:0] hi);
    case (hi)
      BCD_HI_ADD: fam_op = BCD_ADD;
      BCD_HI_ADDC: fam_op = BCD_ADDC;
      BCD_HI_ORL: fam_op = BCD_OR;
      BCD_HI_ANL: fam_op = BCD_AND;
      BCD_HI_XRL: fam_op = BCD_XOR;
      BCD_HI_SUBB: fam_op = BCD_SUBB;
      BCD_HI_MOVA: fam_op = BCD_MOV;
      default: fam_op = BCD_NONE;
    endcase
  endfunction

  logic [3:0] hi;
  logic [3:0] lo;
  bcd_op_t f_op;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];
  assign f_op = fam_op(hi);

  always_comb begin
    op = BCD_NONE;
    src = BCD_SRC_NONE;
    dst = BCD_DST_NONE;
    len = BCD_LEN_ONE;
    mcycles = BCD_MC_ONE;
    known = 1'b1;
    // Accumulator families share one operand layout per low nibble
    if (f_op != BCD_NONE && (opcode[3] || lo == BCD_LO_DIR || lo[3:1] == 3'h3 || lo == BCD_LO_IMM)) begin
      op = f_op;
      dst = BCD_DST_ACC;
      if (opcode[3]) begin
        src = BCD_SRC_REG;
      end else if (lo == BCD_LO_DIR) begin
        src = BCD_SRC_DIR;
        len = BCD_LEN_TWO;
      end else if (lo == BCD_LO_IMM) begin
        src = BCD_SRC_IMM;
        len = BCD_LEN_TWO;
      end else begin
        src = BCD_SRC_IND;
      end
      // The load-immediate lives at 74 instead of E4 (E4 is clear)
      if (hi == BCD_HI_MOVA && lo == BCD_LO_IMM) begin
        op = BCD_CLR;
        src = BCD_SRC_NONE;
        len = BCD_LEN_ONE;
      end
    end else if ((hi == BCD_HI_ANL || hi == BCD_HI_ORL || hi == BCD_HI_XRL) &&
                 (lo == BCD_LO_ACC_TO_DIR || lo == BCD_LO_IMM_TO_DIR)) begin
      op = f_op;
      dst = BCD_DST_DIR;
      len = BCD_LEN_TWO;
      src = BCD_SRC_ACC;
      if (lo == BCD_LO_IMM_TO_DIR) begin
        src = BCD_SRC_IMM;
        len = BCD_LEN_THREE;
        mcycles = BCD_MC_TWO;
      end
    end else begin
      case (hi)
        4'hF: begin
          op = BCD_MOV;
          src = BCD_SRC_ACC;
          if (opcode[3]) dst = BCD_DST_REG;
          else if (lo[3:1] == 3'h3) dst = BCD_DST_IND;
          else if (opcode == BCD_OP_A_TO_DIR) begin
            dst = BCD_DST_DIR;
            len = BCD_LEN_TWO;
          end else if (lo[3:1] == 3'h1) begin
            op = BCD_XWR;
            dst = BCD_DST_XDATA;
            src = BCD_SRC_IND;
            mcycles = BCD_MC_TWO;
          end else if (opcode == BCD_OP_XWR_DPTR) begin
            op = BCD_XWR;
            dst = BCD_DST_XDATA;
            src = BCD_SRC_DPTR;
            mcycles = BCD_MC_TWO;
          end else if (opcode == BCD_OP_CPL_A) begin
            op = BCD_CPL;
            dst = BCD_DST_ACC;
          end else known = 1'b0;
        end
        4'h7: begin
          op = BCD_MOV;
          src = BCD_SRC_IMM;
          len = BCD_LEN_TWO;
          if (opcode[3]) dst = BCD_DST_REG;
          else if (lo[3:1] == 3'h3) dst = BCD_DST_IND;
          else if (opcode == BCD_OP_IMM_TO_DIR) begin
            dst = BCD_DST_DIR;
            len = BCD_LEN_THREE;
            mcycles = BCD_MC_TWO;
          end else if (opcode == BCD_OP_IMM_TO_A) dst = BCD_DST_ACC;
          else known = 1'b0;
        end
        4'hA: begin
          op = BCD_MOV;
          src = BCD_SRC_DIR;
          len = BCD_LEN_TWO;
          mcycles = BCD_MC_TWO;
          if (opcode[3]) dst = BCD_DST_REG;
          else if (lo[3:1] == 3'h3) dst = BCD_DST_IND;
          else known = 1'b0;
        end
        4'h8: begin
          op = BCD_MOV;
          dst = BCD_DST_DIR;
          len = BCD_LEN_TWO;
          mcycles = BCD_MC_TWO;
          if (opcode[3]) src = BCD_SRC_REG;
          else if (lo[3:1] == 3'h3) src = BCD_SRC_IND;
          else if (opcode == BCD_OP_DIR_TO_DIR) begin
            src = BCD_SRC_DIR;
            len = BCD_LEN_THREE;
          end else known = 1'b0;
        end
        4'hC: begin
          op = BCD_XCH;
          dst = BCD_DST_ACC;
          if (opcode[3]) src = BCD_SRC_REG;
          else if (lo[3:1] == 3'h3) src = BCD_SRC_IND;
          else if (opcode == BCD_OP_XCH_DIR) begin
            src = BCD_SRC_DIR;
            len = BCD_LEN_TWO;
          end else known = 1'b0;
        end
        4'hD: begin
          if (lo[3:1] == 3'h3) begin
            op = BCD_XCHD;
            src = BCD_SRC_IND;
            dst = BCD_DST_ACC;
          end else known = 1'b0;
        end
        4'hE: begin
          if (lo[3:1] == 3'h1) begin
            op = BCD_XRD;
            src = BCD_SRC_IND;
            dst = BCD_DST_ACC;
            mcycles = BCD_MC_TWO;
          end else known = 1'b0;
        end
        default: known = 1'b0;
      endcase
      // Single-opcode instructions override the nibble groups
      case (opcode)
        BCD_OP_MUL, BCD_OP_DIV: begin
          op = (opcode == BCD_OP_MUL) ? BCD_MUL : BCD_DIV;
          src = BCD_SRC_NONE;
          dst = BCD_DST_ACC;
          len = BCD_LEN_ONE;
          mcycles = BCD_MC_FOUR;
          known = 1'b1;
        end
        BCD_OP_SWAP_A, BCD_OP_ROT_L, BCD_OP_ROT_LC, BCD_OP_ROT_R, BCD_OP_ROT_RC: begin
          op = (opcode == BCD_OP_SWAP_A) ? BCD_SWAP : (opcode == BCD_OP_ROT_L) ? BCD_RL :
               (opcode == BCD_OP_ROT_LC) ? BCD_RLC : (opcode == BCD_OP_ROT_R) ? BCD_RR : BCD_RRC;
          src = BCD_SRC_ACC;
          dst = BCD_DST_ACC;
          len = BCD_LEN_ONE;
          mcycles = BCD_MC_ONE;
          known = 1'b1;
        end
        BCD_OP_LD_DPTR, BCD_OP_INC_DPTR: begin
          op = (opcode == BCD_OP_LD_DPTR) ? BCD_LD_DPTR : BCD_INC_DPTR;
          src = (opcode == BCD_OP_LD_DPTR) ? BCD_SRC_IMM : BCD_SRC_DPTR;
          dst = BCD_DST_DPTR;
          len = (opcode == BCD_OP_LD_DPTR) ? BCD_LEN_THREE : BCD_LEN_ONE;
          mcycles = BCD_MC_TWO;
          known = 1'b1;
        end
        BCD_OP_CODE_DPTR, BCD_OP_CODE_PC: begin
          op = BCD_MOVC;
          src = (opcode == BCD_OP_CODE_DPTR) ? BCD_SRC_DPTR : BCD_SRC_PC;
          dst = BCD_DST_ACC;
          len = BCD_LEN_ONE;
          mcycles = BCD_MC_TWO;
          known = 1'b1;
        end
        BCD_OP_XRD_DPTR: begin
          op = BCD_XRD;
          src = BCD_SRC_DPTR;
          dst = BCD_DST_ACC;
          len = BCD_LEN_ONE;
          mcycles = BCD_MC_TWO;
          known = 1'b1;
        end
        BCD_OP_PUSH, BCD_OP_POP: begin
          op = (opcode == BCD_OP_PUSH) ? BCD_PUSH : BCD_POP;
          src = (opcode == BCD_OP_PUSH) ? BCD_SRC_DIR : BCD_SRC_NONE;
          dst = (opcode == BCD_OP_PUSH) ? BCD_DST_STACK : BCD_DST_DIR;
          len = BCD_LEN_TWO;
          mcycles = BCD_MC_TWO;
          known = 1'b1;
        end
        default: ;
      endcase
    end
    if (!known) begin
      op = BCD_NONE;
      src = BCD_SRC_NONE;
      dst = BCD_DST_NONE;
      len = BCD_LEN_ONE;
      mcycles = BCD_MC_ONE;
    end
  end
endmodule

// ===== inc/bcd_pkg.sv
/*
  Constants and types for the byte-core opcode decoder: opcode values,
  operation classes, operand sources, lengths and cycle counts.
  Assumes a single clock where one machine cycle is two clock periods.
*/
package bcd_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned BCD_CLKS_PER_MC = 2;
  localparam logic [2:0] BCD_MC_ONE = 3'h1;
  localparam logic [2:0] BCD_MC_TWO = 3'h2;
  localparam logic [2:0] BCD_MC_FOUR = 3'h4;
  localparam logic [1:0] BCD_LEN_ONE = 2'h1;
  localparam logic [1:0] BCD_LEN_TWO = 2'h2;
  localparam logic [1:0] BCD_LEN_THREE = 2'h3;

  // ==========================================================
  // Single opcodes
  localparam logic [7:0] BCD_OP_MUL = 8'hA4;
  localparam logic [7:0] BCD_OP_DIV = 8'h84;
  localparam logic [7:0] BCD_OP_CLR_A = 8'hE4;
  localparam logic [7:0] BCD_OP_CPL_A = 8'hF4;
  localparam logic [7:0] BCD_OP_SWAP_A = 8'hC4;
  localparam logic [7:0] BCD_OP_ROT_L = 8'h23;
  localparam logic [7:0] BCD_OP_ROT_LC = 8'h33;
  localparam logic [7:0] BCD_OP_ROT_R = 8'h03;
  localparam logic [7:0] BCD_OP_ROT_RC = 8'h13;
  localparam logic [7:0] BCD_OP_LD_DPTR = 8'h90;
  localparam logic [7:0] BCD_OP_INC_DPTR = 8'hA3;
  localparam logic [7:0] BCD_OP_CODE_DPTR = 8'h93;
  localparam logic [7:0] BCD_OP_CODE_PC = 8'h83;
  localparam logic [7:0] BCD_OP_XRD_DPTR = 8'hE0;
  localparam logic [7:0] BCD_OP_XWR_DPTR = 8'hF0;
  localparam logic [7:0] BCD_OP_PUSH = 8'hC0;
  localparam logic [7:0] BCD_OP_POP = 8'hD0;
  localparam logic [7:0] BCD_OP_A_TO_DIR = 8'hF5;
  localparam logic [7:0] BCD_OP_DIR_TO_DIR = 8'h85;
  localparam logic [7:0] BCD_OP_IMM_TO_DIR = 8'h75;
  localparam logic [7:0] BCD_OP_IMM_TO_A = 8'h74;
  localparam logic [7:0] BCD_OP_XCH_DIR = 8'hC5;

  // High nibbles of the accumulator-operand families
  localparam logic [3:0] BCD_HI_ADD = 4'h2;
  localparam logic [3:0] BCD_HI_ADDC = 4'h3;
  localparam logic [3:0] BCD_HI_ORL = 4'h4;
  localparam logic [3:0] BCD_HI_ANL = 4'h5;
  localparam logic [3:0] BCD_HI_XRL = 4'h6;
  localparam logic [3:0] BCD_HI_SUBB = 4'h9;
  localparam logic [3:0] BCD_HI_MOVA = 4'hE;

  // Low nibbles of the operand forms within a family
  localparam logic [3:0] BCD_LO_IMM = 4'h4;
  localparam logic [3:0] BCD_LO_DIR = 4'h5;
  localparam logic [3:0] BCD_LO_ACC_TO_DIR = 4'h2;
  localparam logic [3:0] BCD_LO_IMM_TO_DIR = 4'h3;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    BCD_NONE, BCD_ADD, BCD_ADDC, BCD_SUBB, BCD_AND, BCD_OR, BCD_XOR,
    BCD_CLR, BCD_CPL, BCD_SWAP, BCD_RL, BCD_RLC, BCD_RR, BCD_RRC,
    BCD_MUL, BCD_DIV, BCD_MOV, BCD_LD_DPTR, BCD_INC_DPTR, BCD_MOVC,
    BCD_XRD, BCD_XWR, BCD_PUSH, BCD_POP, BCD_XCH, BCD_XCHD
  } bcd_op_t;

  typedef enum logic [2:0] {
    BCD_SRC_NONE, BCD_SRC_ACC, BCD_SRC_REG, BCD_SRC_DIR, BCD_SRC_IND,
    BCD_SRC_IMM, BCD_SRC_DPTR, BCD_SRC_PC
  } bcd_src_t;

  typedef enum logic [2:0] {
    BCD_DST_NONE, BCD_DST_ACC, BCD_DST_REG, BCD_DST_DIR, BCD_DST_IND,
    BCD_DST_DPTR, BCD_DST_XDATA, BCD_DST_STACK
  } bcd_dst_t;
endpackage

// ===== rtl/bcd_mc_timer.sv
/*
  Machine-cycle timer: a phase bit that splits each machine cycle into
  two clock periods and counts machine cycles of the running instruction.
  Assumes start is only raised while idle.
*/
`timescale 1ns/100ps
module bcd_mc_timer
  import bcd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [2:0] mcycles,
  output logic busy,
  output logic mc_tick,
  output logic last
);
  logic phase_q;
  logic [2:0] left_q;

  // Second clock of a machine cycle ends it
  assign mc_tick = busy && phase_q;
  assign last = mc_tick && (left_q == 3'h1);
  assign busy = (left_q != 3'h0);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 1'b0;
    end else if (clk_en) begin
      phase_q <= busy ? ~phase_q : 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 3'h0;
    end else if (clk_en) begin
      if (start && !busy) begin
        left_q <= mcycles;
      end else if (mc_tick) begin
        left_q <= left_q - 3'h1;
      end
    end
  end
endmodule

// ===== rtl/bcd_decoder.sv
/*
  Opcode decoder and sequencer for the 8-bit accumulator core.
  Takes bytes from the program fetch path, collects operands, then
  holds a decoded instruction for its machine-cycle count.
  Assumes fetch data is valid in the cycle fetch_valid is high.
*/
`timescale 1ns/100ps
module bcd_decoder
  import bcd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_data,
  output logic fetch_ready,
  output logic exec_valid,
  output logic exec_mc_tick,
  output logic exec_done,
  output bcd_op_t exec_op,
  output bcd_src_t exec_src,
  output bcd_dst_t exec_dst,
  output logic [7:0] exec_opcode,
  output logic [2:0] exec_reg,
  output logic exec_ptr,
  output logic [7:0] exec_operand1,
  output logic [7:0] exec_operand2,
  output logic [1:0] exec_len,
  output logic [2:0] exec_mcycles,
  output logic exec_illegal
);
  typedef enum logic [1:0] {BCD_ST_OPCODE, BCD_ST_OPND1, BCD_ST_OPND2, BCD_ST_EXEC} bcd_state_t;

  // ==========================================================
  // Opcode lookup
  bcd_op_t tab_op;
  bcd_src_t tab_src;
  bcd_dst_t tab_dst;
  logic [1:0] tab_len;
  logic [2:0] tab_mc;
  logic tab_known;

  bcd_opcode_table u_table (
    .opcode(fetch_data),
    .op(tab_op),
    .src(tab_src),
    .dst(tab_dst),
    .len(tab_len),
    .mcycles(tab_mc),
    .known(tab_known)
  );

  // ==========================================================
  // Fetch sequence
  bcd_state_t state_q;
  bcd_state_t state_d;
  logic take;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_tick;
  logic tmr_last;

  // Bytes are accepted only while collecting; execution stalls fetch
  assign fetch_ready = (state_q != BCD_ST_EXEC);
  assign take = fetch_valid && fetch_ready && clk_en;

  always_comb begin
    state_d = state_q;
    case (state_q)
      BCD_ST_OPCODE: begin
        if (take) begin
          state_d = (tab_len == BCD_LEN_ONE) ? BCD_ST_EXEC : BCD_ST_OPND1;
        end
      end
      BCD_ST_OPND1: begin
        if (take) begin
          state_d = (exec_len == BCD_LEN_THREE) ? BCD_ST_OPND2 : BCD_ST_EXEC;
        end
      end
      BCD_ST_OPND2: begin
        if (take) begin
          state_d = BCD_ST_EXEC;
        end
      end
      BCD_ST_EXEC: begin
        if (tmr_last) begin
          state_d = BCD_ST_OPCODE;
        end
      end
      default: state_d = BCD_ST_OPCODE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= BCD_ST_OPCODE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Decoded instruction hold
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      exec_op <= BCD_NONE;
      exec_src <= BCD_SRC_NONE;
      exec_dst <= BCD_DST_NONE;
      exec_opcode <= 8'h00;
      exec_reg <= 3'h0;
      exec_ptr <= 1'b0;
      exec_len <= BCD_LEN_ONE;
      exec_mcycles <= BCD_MC_ONE;
      exec_illegal <= 1'b0;
    end else if (take && state_q == BCD_ST_OPCODE) begin
      exec_op <= tab_op;
      exec_src <= tab_src;
      exec_dst <= tab_dst;
      exec_opcode <= fetch_data;
      exec_reg <= fetch_data[2:0];
      exec_ptr <= fetch_data[0];
      exec_len <= tab_len;
      exec_mcycles <= tab_mc;
      // Unknown codes run as a one-cycle no-op and flag it
      exec_illegal <= !tab_known;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      exec_operand1 <= 8'h00;
      exec_operand2 <= 8'h00;
    end else if (take) begin
      if (state_q == BCD_ST_OPCODE) begin
        exec_operand1 <= 8'h00;
        exec_operand2 <= 8'h00;
      end else if (state_q == BCD_ST_OPND1) begin
        exec_operand1 <= fetch_data;
      end else if (state_q == BCD_ST_OPND2) begin
        exec_operand2 <= fetch_data;
      end
    end
  end

  // ==========================================================
  // Execution timing
  assign tmr_start = (state_q == BCD_ST_EXEC) && !tmr_busy && !exec_valid;

  // Timer starts the first cycle of execute; valid marks the run
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      exec_valid <= 1'b0;
    end else if (clk_en) begin
      if (tmr_last) begin
        exec_valid <= 1'b0;
      end else if (tmr_start) begin
        exec_valid <= 1'b1;
      end
    end
  end

  bcd_mc_timer u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .start(tmr_start),
    .mcycles(exec_mcycles),
    .busy(tmr_busy),
    .mc_tick(tmr_tick),
    .last(tmr_last)
  );

  assign exec_mc_tick = tmr_tick && clk_en;
  assign exec_done = tmr_last && clk_en;
endmodule

// ===== testbench/bcd_decoder_checker.sv
/*
  Timing checker for the opcode decoder: fetch refusal, machine-cycle
  pacing and held fields. Sees only the decoder's ports; bound below.
*/
`timescale 1ns/100ps
module bcd_decoder_checker
  import bcd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic fetch_ready,
  input wire logic exec_valid,
  input wire logic exec_mc_tick,
  input wire logic exec_done,
  input wire bcd_op_t exec_op,
  input wire logic [7:0] exec_opcode,
  input wire logic [2:0] exec_reg,
  input wire logic exec_ptr,
  input wire logic [1:0] exec_len,
  input wire logic [2:0] exec_mcycles,
  input wire logic exec_illegal
);
  // ==========================================================
  // Ticks seen so far in the running instruction
  logic [2:0] tick_cnt_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 3'h0;
    end else if (!exec_valid) begin
      tick_cnt_q <= 3'h0;
    end else if (exec_mc_tick) begin
      tick_cnt_q <= tick_cnt_q + 3'h1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence start_s;
    $rose(exec_valid);
  endsequence
  sequence finish_s;
    exec_done && clk_en;
  endsequence
  sequence mid_tick_s;
    exec_mc_tick && !exec_done && clk_en;
  endsequence

  // ==========================================================
  // Assertions
  ready_low_a: assert property (exec_valid |-> !fetch_ready)
    else $error("byte accepted during execution");
  first_phase_a: assert property (start_s |-> !exec_mc_tick)
    else $error("tick in first clock of execution");
  tick_gap_a: assert property (mid_tick_s |=> !exec_mc_tick)
    else $error("ticks on adjacent clocks");
  tick_pair_a: assert property (mid_tick_s ##1 clk_en ##1 clk_en |-> exec_mc_tick)
    else $error("tick missing two clocks after previous");
  done_count_a: assert property (exec_done |-> exec_mc_tick && tick_cnt_q + 3'h1 == exec_mcycles)
    else $error("done not on final machine cycle");
  release_a: assert property (finish_s |=> !exec_valid && fetch_ready)
    else $error("execution not released after done");
  long_ops_a: assert property (exec_valid && (exec_opcode == BCD_OP_MUL || exec_opcode == BCD_OP_DIV)
    |-> exec_mcycles == BCD_MC_FOUR && exec_len == BCD_LEN_ONE) else $error("multiply or divide timing");
  reg_field_a: assert property (exec_valid |-> exec_reg == exec_opcode[2:0] && exec_ptr == exec_opcode[0])
    else $error("register or pointer select wrong");
  mc_set_a: assert property (exec_valid |-> exec_mcycles inside {3'h1, 3'h2, 3'h4} && exec_len != 2'h0)
    else $error("illegal length or cycle count");
  bad_op_a: assert property (exec_valid && exec_illegal |-> exec_op == BCD_NONE && exec_mcycles == BCD_MC_ONE)
    else $error("unknown opcode not run as one cycle");
  held_a: assert property (exec_valid && !exec_done |=> $stable(exec_opcode) && $stable(exec_len))
    else $error("decoded fields changed during execution");
endmodule

bind bcd_decoder bcd_decoder_checker u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .fetch_ready(fetch_ready),
  .exec_valid(exec_valid), .exec_mc_tick(exec_mc_tick), .exec_done(exec_done), .exec_op(exec_op),
  .exec_opcode(exec_opcode), .exec_reg(exec_reg), .exec_ptr(exec_ptr), .exec_len(exec_len),
  .exec_mcycles(exec_mcycles), .exec_illegal(exec_illegal)
);

// ===== testbench/bcd_fetch_model.sv
/*
  Program memory fetch model: offers queued bytes with random gaps and
  holds each until taken. Assumes the bench fills q.
*/
`timescale 1ns/100ps
module bcd_fetch_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [7:0] fetch_data
);
  logic [7:0] q[$];
  initial begin
    fetch_valid = 1'b0;
    fetch_data = 8'h00;
  end
  always @(posedge core_clk) begin
    if (fetch_valid && fetch_ready && clk_en && rst_b && q.size() != 0) begin
      void'(q.pop_front());
    end
    #1;
    // Idle data toggles so a stale byte can never be mistaken for a fresh one
    if (rst_b && q.size() != 0 && (fetch_valid || $urandom_range(3) != 0)) begin
      fetch_valid = 1'b1;
      fetch_data = q[0];
    end else begin
      fetch_valid = 1'b0;
      fetch_data = ~fetch_data;
    end
  end
endmodule

// ===== testbench/bcd_decoder_tb.sv
/*
  Self-checking bench for the opcode decoder: every covered opcode, random
  streams with a stalling fetch side and clock-enable gaps, reset mid-run.
  Assumes the fetch model and bound checker beside it.
*/
`timescale 1ns/100ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module bcd_decoder_tb;
  import bcd_pkg::*;
  logic core_clk, rst_b, clk_en, fetch_valid, fetch_ready, exec_valid, exec_mc_tick, exec_done;
  logic exec_ptr, exec_illegal;
  logic [7:0] fetch_data, exec_opcode, exec_operand1, exec_operand2, o;
  logic [2:0] exec_reg, exec_mcycles;
  logic [1:0] exec_len;
  bcd_op_t exec_op;
  bcd_src_t exec_src;
  bcd_dst_t exec_dst;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;

  bcd_decoder dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .fetch_ready(fetch_ready), .exec_valid(exec_valid),
    .exec_mc_tick(exec_mc_tick), .exec_done(exec_done), .exec_op(exec_op), .exec_src(exec_src),
    .exec_dst(exec_dst), .exec_opcode(exec_opcode), .exec_reg(exec_reg), .exec_ptr(exec_ptr),
    .exec_operand1(exec_operand1), .exec_operand2(exec_operand2), .exec_len(exec_len),
    .exec_mcycles(exec_mcycles), .exec_illegal(exec_illegal));
  bcd_fetch_model fm (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Expected {length, machine cycles}; zero for uncovered codes
  function automatic logic [4:0] ref_lm(input logic [7:0] c);
    case (c) inside
      [8'h28:8'h2F], [8'h38:8'h3F], [8'h98:8'h9F], [8'h48:8'h4F], [8'h58:8'h5F], [8'h68:8'h6F],
      8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97, 8'h46, 8'h47, 8'h56, 8'h57, 8'h66, 8'h67,
      8'hE4, 8'hF4, 8'hC4, 8'h23, 8'h33, 8'h03, 8'h13, [8'hE8:8'hEF], 8'hE6, 8'hE7, [8'hF8:8'hFF],
      8'hF6, 8'hF7, [8'hC8:8'hCF], 8'hC6, 8'hC7, 8'hD6, 8'hD7: return 5'h09;
      8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95, 8'h44, 8'h45, 8'h54, 8'h55, 8'h64, 8'h65, 8'h42,
      8'h52, 8'h62, 8'hE5, 8'h74, [8'h78:8'h7F], 8'hF5, 8'h76, 8'h77, 8'hC5: return 5'h11;
      [8'hA8:8'hAF], [8'h88:8'h8F], 8'h86, 8'h87, 8'hA6, 8'hA7, 8'hC0, 8'hD0: return 5'h12;
      8'h43, 8'h53, 8'h63, 8'h85, 8'h75, 8'h90: return 5'h1A;
      8'hA3, 8'h93, 8'h83, 8'hE2, 8'hE3, 8'hE0, 8'hF2, 8'hF3, 8'hF0: return 5'h0A;
      8'hA4, 8'h84: return 5'h0C;
      default: return 5'h00;
    endcase
  endfunction

  // Expected operation class; uncovered codes run as no-ops
  function automatic bcd_op_t ref_op(input logic [7:0] c);
    if (ref_lm(c) == 5'h00) return BCD_NONE;
    case (c) inside
      8'hA4: return BCD_MUL;
      8'h84: return BCD_DIV;
      8'hE4: return BCD_CLR;
      8'hF4: return BCD_CPL;
      8'hC4: return BCD_SWAP;
      8'h23: return BCD_RL;
      8'h33: return BCD_RLC;
      8'h03: return BCD_RR;
      8'h13: return BCD_RRC;
      8'h90: return BCD_LD_DPTR;
      8'hA3: return BCD_INC_DPTR;
      8'h93, 8'h83: return BCD_MOVC;
      8'hE0, 8'hE2, 8'hE3: return BCD_XRD;
      8'hF0, 8'hF2, 8'hF3: return BCD_XWR;
      8'hC0: return BCD_PUSH;
      8'hD0: return BCD_POP;
      8'hD6, 8'hD7: return BCD_XCHD;
      [8'hC5:8'hCF]: return BCD_XCH;
      [8'h24:8'h2F]: return BCD_ADD;
      [8'h34:8'h3F]: return BCD_ADDC;
      [8'h94:8'h9F]: return BCD_SUBB;
      [8'h42:8'h4F]: return BCD_OR;
      [8'h52:8'h5F]: return BCD_AND;
      [8'h62:8'h6F]: return BCD_XOR;
      default: return BCD_MOV;
    endcase
  endfunction

  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    logic [4:0] lm;
    logic [1:0] el;
    logic [2:0] em;
    int n;
    int ticks;
    lm = ref_lm(op);
    el = (lm == 5'h00) ? 2'h1 : lm[4:3];
    em = (lm == 5'h00) ? 3'h1 : lm[2:0];
    fm.q.push_back(op);
    if (el > 2'h1) fm.q.push_back(b1);
    if (el > 2'h2) fm.q.push_back(b2);
    n = 0;
    do begin
      @(posedge core_clk);
      #2;
      n++;
    end while (exec_valid !== 1'b1 && n < 60);
    `CHK("opcode", op, exec_opcode)
    `CHK("len", el, exec_len)
    `CHK("mcycles", em, exec_mcycles)
    `CHK("illegal", lm == 5'h00, exec_illegal)
    `CHK("op", ref_op(op), exec_op)
    `CHK("reg_use", op[3] && lm != 5'h00, exec_src == BCD_SRC_REG || exec_dst == BCD_DST_REG)
    `CHK("ind_use", lm != 5'h00 && (op[3:1] == 3'h3 || op inside {8'hE2, 8'hE3, 8'hF2, 8'hF3}),
      exec_src == BCD_SRC_IND || exec_dst == BCD_DST_IND)
    `CHK("reg", op[2:0], exec_reg)
    `CHK("ptr", op[0], exec_ptr)
    `CHK("opnd1", el > 2'h1 ? b1 : 8'h00, exec_operand1)
    `CHK("opnd2", el > 2'h2 ? b2 : 8'h00, exec_operand2)
    n = 0;
    ticks = 0;
    forever begin
      if (clk_en === 1'b1) begin
        n++;
        ticks += int'(exec_mc_tick === 1'b1);
      end
      if (exec_done === 1'b1 || n > 40) break;
      @(posedge core_clk);
      #2;
    end
    `CHK("ticks", em, ticks[2:0])
    `CHK("clocks", {em, 1'b0}, n[3:0])
  endtask

  task automatic end_sim;
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Enable gaps stretch machine cycles without changing their count
  always @(posedge core_clk) begin
    clk_en <= #1 (rst_b !== 1'b1) || ($urandom_range(7) != 0);
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim;
    end
  end

  initial begin
    void'($urandom(86403));
    rst_b = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 rst_b = 1'b1;
    `CHK("ready_rst", 1'b1, fetch_ready)
    `CHK("len_rst", BCD_LEN_ONE, exec_len)
    for (int i = 0; i < 256; i++) begin
      if (ref_lm(i[7:0]) != 5'h00) run(i[7:0], 8'($urandom), 8'($urandom));
    end
    run(8'hB5, 8'hFF, 8'h00);
    run(BCD_OP_IMM_TO_DIR, 8'h00, 8'hFF);
    repeat (300) begin
      do o = 8'($urandom); while (ref_lm(o) == 5'h00);
      run(o, 8'($urandom), 8'($urandom));
    end
    fm.q.push_back(BCD_OP_MUL);
    repeat (6) @(posedge core_clk);
    #1 rst_b = 1'b0;
    fm.q.delete();
    @(posedge core_clk);
    #1 rst_b = 1'b1;
    #1;
    `CHK("valid_rst", 1'b0, exec_valid)
    `CHK("ready_rst2", 1'b1, fetch_ready)
    run(BCD_OP_DIV, 8'h00, 8'h00);
    end_sim;
  end
endmodule
